// file: include/vts_pkg.sv
// Package: address map, signature layout and carrier types of the vector region
package vts_pkg;

    // Region bounds: top word down to the lowest signature word
    localparam logic [15:0] VTS_REGION_TOP = 16'hFFFF;
    localparam logic [15:0] VTS_REGION_BASE = 16'hFF80;
    localparam logic [8:0] VTS_REGION_TAG = 9'h1FF;
    localparam int VTS_WORDS = 64;
    localparam int VTS_IDX_W = 6;

    // Reset vector word and first interrupt slot below it
    localparam logic [15:0] VTS_RESET_VEC_ADDR = 16'hFFFE;
    localparam logic [15:0] VTS_IRQ_TOP_ADDR = 16'hFFFC;
    localparam logic [5:0] VTS_IRQ_MAX_SLOT = 6'h3E;

    // Signature words, allocated upward from the region base
    localparam logic [15:0] VTS_SIG_DBG_ADDR = 16'hFF80;
    localparam logic [15:0] VTS_SIG_BL_ADDR = 16'hFF84;
    localparam logic [15:0] VTS_BL_ENABLE_KEY = 16'hA5A5;
    localparam int VTS_DBG_LEN_LSB = 0;
    localparam int VTS_DBG_LEN_W = 6;
    localparam logic [5:0] VTS_DBG_LEN_MAX = 6'h3C;

    // Password windows
    localparam logic [15:0] VTS_BL_PW_LOW_ADDR = 16'hFFE0;
    localparam logic [15:0] VTS_DBG_PW_ADDR = 16'hFF88;

    // Reset value of the stored words (erased memory)
    localparam logic [15:0] VTS_ERASED_WORD = 16'hFFFF;

    // Reset causes, each an asynchronous level from outside
    typedef struct packed {
        logic power_up;
        logic brownout;
        logic supervisor;
        logic pin;
    } vts_cause_t;

    // Sticky reset-cause flags
    typedef struct packed {
        logic supply_supervisor_reset_flag;
        logic external_pin_reset_flag;
    } vts_flags_t;

    // One password word offered for comparison
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } vts_pw_t;

endpackage : vts_pkg

// file: src/vts_sync.sv
// Two-stage synchroniser for a group of asynchronous levels
module vts_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // One flop pair per bit; the first stage feeds only the second
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (!resetn) begin
                meta_q[i] <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_q[i] <= async_in[i];
                sync_out[i] <= meta_q[i];
            end
        end
    end

endmodule : vts_sync

// file: src/vts_vector_map.sv
// Top-of-memory vector region: reset entry, interrupt vectors, signatures, passwords
//
// How it works
// - All vectors and signatures live in FF80h-FFFFh
// - Start address comes from word FFFEh
// - Interrupt slots grow downward from FFFCh
// - Slots 0-62 each yield full 16-bit handler address; slot 63 is refused
// - Bootloader password checks FFFEh down to FFE0h
// - Signature words grow upward from FF80h
// - Signatures evaluated at every start-up first
// - Debug password read upward from FF88h
// - Debug password may run into vector slots
// - Debug signature sets debug password length
// - Reset causes restart via vector, set flags
module vts_vector_map
    import vts_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire vts_cause_t CAUSE,
    input wire vts_flags_t FLAG_CLR,
    input wire logic PROG_WE,
    input wire logic [15:0] PROG_ADDR,
    input wire logic [15:0] PROG_DATA,
    input wire logic IRQ_REQ,
    input wire logic [5:0] IRQ_SLOT,
    input wire vts_pw_t BL_PW,
    input wire vts_pw_t DBG_PW,
    output logic CPU_HOLD,
    output logic SIG_DONE,
    output logic START_VALID,
    output logic [15:0] START_ADDR,
    output logic HANDLER_VALID,
    output logic [15:0] HANDLER_ADDR,
    output vts_flags_t RESET_FLAGS,
    output logic BL_PW_REQUIRED,
    output logic BL_PW_DONE,
    output logic BL_PW_OK,
    output logic [5:0] DBG_PW_LEN,
    output logic DBG_PW_DONE,
    output logic DBG_PW_OK
);

    typedef enum logic [2:0] {
        ST_SIG_DBG,
        ST_SIG_BL,
        ST_VEC,
        ST_RUN
    } vts_state_t;

    // Word-aligned address to array index; low bit dropped
    function automatic logic [VTS_IDX_W-1:0] word_idx(input logic [15:0] addr);
        word_idx = addr[VTS_IDX_W:1];
    endfunction : word_idx

    // True when an address falls inside the vector region
    function automatic logic in_region(input logic [15:0] addr);
        in_region = (addr[15:7] == VTS_REGION_TAG);
    endfunction : in_region

    logic [15:0] mem_q [VTS_WORDS];
    logic [3:0] cause_s;
    logic any_cause;
    vts_state_t state_q;
    vts_state_t state_d;
    logic [5:0] dbg_len_q;
    logic bl_en_q;
    logic [VTS_IDX_W-1:0] bl_idx_q;
    logic bl_bad_q;
    logic [VTS_IDX_W-1:0] dbg_idx_q;
    logic [5:0] dbg_cnt_q;
    logic dbg_bad_q;
    logic [VTS_IDX_W-1:0] irq_idx;
    logic [15:0] bl_word;
    logic [15:0] dbg_word;
    logic [15:0] sig_dbg_word;
    logic [5:0] sig_len;

    // Bring the asynchronous reset causes into the clock domain
    vts_sync #(
        .WIDTH(4)
    ) u_cause_sync (
        .clk(CLK),
        .resetn(RESETN),
        .async_in(CAUSE),
        .sync_out(cause_s)
    );

    assign any_cause = |cause_s;

    // Stored region contents; writes outside FF80h-FFFFh are ignored
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            for (int i = 0; i < VTS_WORDS; i++) begin
                mem_q[i] <= VTS_ERASED_WORD;
            end
        end else if (PROG_WE && in_region(PROG_ADDR)) begin
            mem_q[word_idx(PROG_ADDR)] <= PROG_DATA;
        end
    end

    // Start-up sequence next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_SIG_DBG: state_d = ST_SIG_BL;
            ST_SIG_BL: state_d = ST_VEC;
            ST_VEC: state_d = ST_RUN;
            ST_RUN: state_d = ST_RUN;
            default: state_d = ST_SIG_DBG;
        endcase
        if (any_cause) begin
            state_d = ST_SIG_DBG;
        end
    end

    // Sequencer state register
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state_q <= ST_SIG_DBG;
        end else begin
            state_q <= state_d;
        end
    end

    // Debug signature length field, clamped to the words above FF88h
    assign sig_dbg_word = mem_q[word_idx(VTS_SIG_DBG_ADDR)];
    always_comb begin
        sig_len = sig_dbg_word[VTS_DBG_LEN_LSB +: VTS_DBG_LEN_W];
        if (sig_len > VTS_DBG_LEN_MAX) begin
            sig_len = VTS_DBG_LEN_MAX;
        end
    end

    // Signature evaluation, one word per start-up step
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            dbg_len_q <= 6'h00;
            bl_en_q <= 1'b0;
        end else if (state_q == ST_SIG_DBG && !any_cause) begin
            dbg_len_q <= sig_len;
        end else if (state_q == ST_SIG_BL && !any_cause) begin
            bl_en_q <= (mem_q[word_idx(VTS_SIG_BL_ADDR)] == VTS_BL_ENABLE_KEY);
        end
    end

    // CPU held until signatures and reset vector are through
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            CPU_HOLD <= 1'b1;
            SIG_DONE <= 1'b0;
        end else begin
            CPU_HOLD <= (state_d != ST_RUN);
            SIG_DONE <= (state_d == ST_VEC) || (state_d == ST_RUN);
        end
    end

    // Application start address fetched from the top word
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            START_VALID <= 1'b0;
            START_ADDR <= 16'h0000;
        end else if (state_q == ST_VEC && !any_cause) begin
            START_VALID <= 1'b1;
            START_ADDR <= mem_q[word_idx(VTS_RESET_VEC_ADDR)];
        end else begin
            START_VALID <= 1'b0;
        end
    end

    // Slot n sits at FFFCh minus two bytes per slot
    assign irq_idx = word_idx(VTS_IRQ_TOP_ADDR) - IRQ_SLOT;

    // Interrupt vector fetch, answered one cycle after the request
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            HANDLER_VALID <= 1'b0;
            HANDLER_ADDR <= 16'h0000;
        end else if (IRQ_REQ && state_q == ST_RUN && !any_cause
                     && IRQ_SLOT <= VTS_IRQ_MAX_SLOT) begin
            HANDLER_VALID <= 1'b1;
            HANDLER_ADDR <= mem_q[irq_idx];
        end else begin
            HANDLER_VALID <= 1'b0;
        end
    end

    // Sticky cause flags; a new cause wins over a clear
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            RESET_FLAGS <= '0;
        end else begin
            if (cause_s[3] || cause_s[2] || cause_s[1]) begin
                RESET_FLAGS.supply_supervisor_reset_flag <= 1'b1;
            end else if (FLAG_CLR.supply_supervisor_reset_flag) begin
                RESET_FLAGS.supply_supervisor_reset_flag <= 1'b0;
            end
            if (cause_s[0]) begin
                RESET_FLAGS.external_pin_reset_flag <= 1'b1;
            end else if (FLAG_CLR.external_pin_reset_flag) begin
                RESET_FLAGS.external_pin_reset_flag <= 1'b0;
            end
        end
    end

    // Bootloader password: walk from the reset vector down to FFE0h
    assign bl_word = mem_q[bl_idx_q];
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            bl_idx_q <= word_idx(VTS_RESET_VEC_ADDR);
            bl_bad_q <= 1'b0;
            BL_PW_DONE <= 1'b0;
            BL_PW_OK <= 1'b0;
            BL_PW_REQUIRED <= 1'b0;
        end else begin
            BL_PW_DONE <= 1'b0;
            BL_PW_REQUIRED <= bl_en_q;
            if (state_q != ST_RUN || any_cause) begin
                bl_idx_q <= word_idx(VTS_RESET_VEC_ADDR);
                bl_bad_q <= 1'b0;
                BL_PW_OK <= 1'b0;
            end else if (BL_PW.valid && bl_en_q) begin
                if (bl_idx_q == word_idx(VTS_BL_PW_LOW_ADDR)) begin
                    BL_PW_DONE <= 1'b1;
                    BL_PW_OK <= !bl_bad_q && (BL_PW.data == bl_word);
                    bl_idx_q <= word_idx(VTS_RESET_VEC_ADDR);
                    bl_bad_q <= 1'b0;
                end else begin
                    bl_bad_q <= bl_bad_q || (BL_PW.data != bl_word);
                    bl_idx_q <= bl_idx_q - 6'h01;
                end
            end
        end
    end

    // Debug password: walk upward from FF88h, possibly into vector slots
    assign dbg_word = mem_q[dbg_idx_q];
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            dbg_idx_q <= word_idx(VTS_DBG_PW_ADDR);
            dbg_cnt_q <= 6'h00;
            dbg_bad_q <= 1'b0;
            DBG_PW_DONE <= 1'b0;
            DBG_PW_OK <= 1'b0;
            DBG_PW_LEN <= 6'h00;
        end else begin
            DBG_PW_DONE <= 1'b0;
            DBG_PW_LEN <= dbg_len_q;
            if (state_q != ST_RUN || any_cause) begin
                dbg_idx_q <= word_idx(VTS_DBG_PW_ADDR);
                dbg_cnt_q <= 6'h00;
                dbg_bad_q <= 1'b0;
                DBG_PW_OK <= 1'b0;
            end else if (DBG_PW.valid && dbg_len_q != 6'h00) begin
                if (dbg_cnt_q == dbg_len_q - 6'h01) begin
                    DBG_PW_DONE <= 1'b1;
                    DBG_PW_OK <= !dbg_bad_q && (DBG_PW.data == dbg_word);
                    dbg_idx_q <= word_idx(VTS_DBG_PW_ADDR);
                    dbg_cnt_q <= 6'h00;
                    dbg_bad_q <= 1'b0;
                end else begin
                    dbg_bad_q <= dbg_bad_q || (DBG_PW.data != dbg_word);
                    dbg_idx_q <= dbg_idx_q + 6'h01;
                    dbg_cnt_q <= dbg_cnt_q + 6'h01;
                end
            end
        end
    end

endmodule : vts_vector_map

// file: dv/vts_vector_map_chk.sv
// Checker: timing relations at the vector map ports
module vts_vector_map_chk
    import vts_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire vts_cause_t CAUSE,
    input wire logic IRQ_REQ,
    input wire logic [5:0] IRQ_SLOT,
    input wire vts_pw_t BL_PW,
    input wire vts_pw_t DBG_PW,
    input wire logic CPU_HOLD,
    input wire logic SIG_DONE,
    input wire logic START_VALID,
    input wire logic HANDLER_VALID,
    input wire vts_flags_t RESET_FLAGS,
    input wire logic BL_PW_REQUIRED,
    input wire logic BL_PW_DONE,
    input wire logic [5:0] DBG_PW_LEN,
    input wire logic DBG_PW_DONE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    a_start_one_pulse: assert property (START_VALID |=> !START_VALID)
        else $error("start pulse too long");
    a_start_ends_hold: assert property (START_VALID |-> !CPU_HOLD && $past(CPU_HOLD))
        else $error("start without hold");
    a_run_after_sig: assert property (!CPU_HOLD |-> SIG_DONE)
        else $error("run before signatures");
    a_handler_cause: assert property (HANDLER_VALID |-> $past(IRQ_REQ) && !$past(CPU_HOLD)
        && $past(IRQ_SLOT) != 6'h3F)
        else $error("handler without request");
    a_dbg_len_max: assert property (DBG_PW_LEN <= 6'h3C)
        else $error("debug length over limit");
    a_bl_done_src: assert property (BL_PW_DONE |-> BL_PW_REQUIRED && $past(BL_PW.valid))
        else $error("bootloader done unexpected");
    a_dbg_done_src: assert property (DBG_PW_DONE |-> DBG_PW_LEN != 6'h00
        && $past(DBG_PW.valid))
        else $error("debug done unexpected");
    a_pin_flag_set: assert property (CAUSE.pin [*3] |-> ##[0:1]
        RESET_FLAGS.external_pin_reset_flag)
        else $error("pin flag not set");
    a_cause_holds: assert property (CAUSE.power_up [*3] |-> ##[0:1] CPU_HOLD)
        else $error("cause did not hold cpu");
endmodule : vts_vector_map_chk

bind vts_vector_map vts_vector_map_chk chk_u (.CLK(CLK), .RESETN(RESETN), .CAUSE(CAUSE),
    .IRQ_REQ(IRQ_REQ), .IRQ_SLOT(IRQ_SLOT), .BL_PW(BL_PW), .DBG_PW(DBG_PW),
    .CPU_HOLD(CPU_HOLD), .SIG_DONE(SIG_DONE), .START_VALID(START_VALID),
    .HANDLER_VALID(HANDLER_VALID), .RESET_FLAGS(RESET_FLAGS),
    .BL_PW_REQUIRED(BL_PW_REQUIRED), .BL_PW_DONE(BL_PW_DONE),
    .DBG_PW_LEN(DBG_PW_LEN), .DBG_PW_DONE(DBG_PW_DONE));

// file: dv/vts_cpu_model.sv
// Partner model: CPU side issuing vector fetches and collecting handler words
module vts_cpu_model (
    input wire logic clk,
    input wire logic fetch,
    input wire logic [5:0] slot,
    input wire logic handler_valid,
    input wire logic [15:0] handler_addr,
    output logic irq_req,
    output logic [5:0] irq_slot,
    output logic [7:0] hv_cnt,
    output logic [15:0] hv_acc
);
    timeunit 1ns;
    timeprecision 1ps;
    initial irq_req = 1'b0;
    initial irq_slot = 6'h00;
    initial hv_cnt = 8'h00;
    initial hv_acc = 16'h0000;
    // Slot shows a changing pattern while no fetch is asked
    always @(posedge clk) begin
        irq_req <= fetch;
        irq_slot <= fetch ? slot : ~irq_slot;
    end
    // Count answers and fold their words together
    always @(posedge clk) begin
        if (handler_valid) begin
            hv_cnt <= hv_cnt + 8'h01;
            hv_acc <= hv_acc ^ handler_addr;
        end
    end
endmodule : vts_cpu_model

// file: dv/vts_vector_map_tb.sv
// Testbench: start-up, vector fetch, passwords and reset flags
module vts_vector_map_tb;
    import vts_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0, RESETN = 1'b0, PROG_WE = 1'b0, fetch = 1'b0;
    logic [15:0] PROG_ADDR = 16'h0000, PROG_DATA = 16'h0000, HANDLER_ADDR, START_ADDR, hv_acc;
    logic [5:0] slot = 6'h00, IRQ_SLOT, DBG_PW_LEN;
    logic [7:0] hv_cnt;
    vts_cause_t CAUSE = '0;
    vts_flags_t FLAG_CLR = '0, RESET_FLAGS;
    vts_pw_t BL_PW = '0, DBG_PW = '0;
    logic IRQ_REQ, CPU_HOLD, SIG_DONE, START_VALID, HANDLER_VALID, BL_PW_REQUIRED;
    logic BL_PW_DONE, BL_PW_OK, DBG_PW_DONE, DBG_PW_OK;
    int err_count = 0, total_checks = 0;
    always #5 CLK = ~CLK;
    vts_vector_map dut_u (.CLK(CLK), .RESETN(RESETN), .CAUSE(CAUSE), .FLAG_CLR(FLAG_CLR),
        .PROG_WE(PROG_WE), .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA), .IRQ_REQ(IRQ_REQ),
        .IRQ_SLOT(IRQ_SLOT), .BL_PW(BL_PW), .DBG_PW(DBG_PW), .CPU_HOLD(CPU_HOLD),
        .SIG_DONE(SIG_DONE), .START_VALID(START_VALID), .START_ADDR(START_ADDR),
        .HANDLER_VALID(HANDLER_VALID), .HANDLER_ADDR(HANDLER_ADDR), .RESET_FLAGS(RESET_FLAGS),
        .BL_PW_REQUIRED(BL_PW_REQUIRED), .BL_PW_DONE(BL_PW_DONE), .BL_PW_OK(BL_PW_OK),
        .DBG_PW_LEN(DBG_PW_LEN), .DBG_PW_DONE(DBG_PW_DONE), .DBG_PW_OK(DBG_PW_OK));
    vts_cpu_model cpu_u (.clk(CLK), .fetch(fetch), .slot(slot), .handler_valid(HANDLER_VALID),
        .handler_addr(HANDLER_ADDR), .irq_req(IRQ_REQ), .irq_slot(IRQ_SLOT),
        .hv_cnt(hv_cnt), .hv_acc(hv_acc));
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Compare one value
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Bounded wait: 0 for start pulse, 1 for a password result
    task automatic wait_for(input int w);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < 20 && !hit; k++) begin
            #1;
            hit = (w == 0) ? (START_VALID === 1'b1) : ((BL_PW_DONE | DBG_PW_DONE) === 1'b1);
            if (!hit) @(posedge CLK);
        end
        if (!hit) begin
            chk("wait", 16'h0001, 16'h0000);
            tally_and_finish();
        end
    endtask : wait_for
    // Hold a cause for four cycles, then wait for the new start
    task automatic restart(input vts_cause_t c);
        @(posedge CLK) CAUSE <= c;
        repeat (4) @(posedge CLK);
        CAUSE <= '0;
        wait_for(0);
    endtask : restart
    // Load vectors at odd addresses and signatures at FF80h and FF84h, then power-up restart
    task automatic t_load_boot();
        for (int a = 16'hFF88; a <= 16'hFFFE; a += 2) begin
            @(posedge CLK) PROG_WE <= 1'b1;
            PROG_ADDR <= 16'(a) | 16'h0001;
            PROG_DATA <= 16'(a) ^ 16'h5A5A;
        end
        @(posedge CLK) PROG_ADDR <= 16'hFF80;
        PROG_DATA <= 16'h0003;
        @(posedge CLK) PROG_ADDR <= 16'hFF84;
        PROG_DATA <= 16'hA5A5;
        @(posedge CLK) PROG_WE <= 1'b0;
        restart('{power_up: 1'b1, default: 1'b0});
        chk("start", 16'hFFFE ^ 16'h5A5A, START_ADDR);
        chk("flags", 16'h0002, 16'(RESET_FLAGS));
        chk("bl_req", 16'h0001, 16'(BL_PW_REQUIRED));
        chk("dbg_len", 16'h0003, 16'(DBG_PW_LEN));
        chk("sig_done", 16'h0001, 16'(SIG_DONE));
        $display("test load_boot done");
    endtask : t_load_boot
    // Back-to-back fetches of slots 0, 1, 62, then refused slot 63
    task automatic t_irq();
        logic [7:0] n0;
        logic [15:0] a0;
        n0 = hv_cnt;
        a0 = hv_acc;
        @(posedge CLK) fetch <= 1'b1;
        slot <= 6'd0;
        @(posedge CLK) slot <= 6'd1;
        @(posedge CLK) slot <= 6'd62;
        @(posedge CLK) fetch <= 1'b0;
        repeat (4) @(posedge CLK);
        #1;
        chk("irq_cnt", 16'h0003, 16'(hv_cnt - n0));
        chk("irq_acc", 16'hFFFC ^ 16'hFFFA ^ 16'h0003, a0 ^ hv_acc);
        @(posedge CLK) fetch <= 1'b1;
        slot <= 6'd63;
        @(posedge CLK) fetch <= 1'b0;
        repeat (4) @(posedge CLK);
        #1;
        chk("irq_63", 16'h0003, 16'(hv_cnt - n0));
        $display("test irq done");
    endtask : t_irq
    // Password walk of n words: 0 bootloader from FFFEh down, 1 debug from FF88h up
    // Word number bad_at is spoilt; a value of n or more leaves all words intact
    task automatic t_pw(input bit dbg, input int n, input int bad_at);
        logic [15:0] w;
        w = 16'h0000;
        for (int i = 0; i < n; i++) begin
            w = (dbg ? 16'hFF88 + 16'(2 * i) : 16'hFFFE - 16'(2 * i)) ^ 16'h5A5A;
            w = w ^ ((i == bad_at) ? 16'h0100 : 16'h0000);
            @(posedge CLK) if (dbg) DBG_PW <= {1'b1, w};
            else BL_PW <= {1'b1, w};
        end
        @(posedge CLK) BL_PW <= {1'b0, ~w};
        DBG_PW <= {1'b0, ~w};
        wait_for(1);
        chk("pw_ok", 16'(bad_at >= n), 16'(dbg ? DBG_PW_OK : BL_PW_OK));
        $display("test pw %0d %0d %0d done", dbg, n, bad_at);
    endtask : t_pw
    // Pin cause sets its flag, clear pulse drops both
    task automatic t_flags();
        restart('{pin: 1'b1, default: 1'b0});
        chk("flags_pin", 16'h0003, 16'(RESET_FLAGS));
        @(posedge CLK) FLAG_CLR <= '1;
        @(posedge CLK) FLAG_CLR <= '0;
        #1;
        chk("flags_clr", 16'h0000, 16'(RESET_FLAGS));
        restart('{brownout: 1'b1, default: 1'b0});
        chk("flags_bor", 16'h0002, 16'(RESET_FLAGS));
        @(posedge CLK) FLAG_CLR <= '1;
        @(posedge CLK) FLAG_CLR <= '0;
        restart('{supervisor: 1'b1, default: 1'b0});
        chk("flags_svs", 16'h0002, 16'(RESET_FLAGS));
        $display("test flags done");
    endtask : t_flags
    // Erased region after reset: start word, clamped length, no bootloader password, CPU let go
    task automatic t_erased();
        wait_for(0);
        chk("erased_start", 16'hFFFF, START_ADDR);
        chk("erased_len", 16'h003C, 16'(DBG_PW_LEN));
        chk("erased_bl", 16'h0000, 16'(BL_PW_REQUIRED));
        chk("run_hold", 16'h0000, 16'(CPU_HOLD));
        $display("test erased done");
    endtask : t_erased
    // Longest debug signature, so the password reaches the vector slots
    task automatic t_dbg_long();
        @(posedge CLK) PROG_WE <= 1'b1;
        PROG_ADDR <= 16'hFF80;
        PROG_DATA <= 16'h003C;
        @(posedge CLK) PROG_WE <= 1'b0;
        restart('{power_up: 1'b1, default: 1'b0});
        chk("dbg_len_long", 16'h003C, 16'(DBG_PW_LEN));
        $display("test dbg_long done");
    endtask : t_dbg_long
    // Main sequence: erased start, then each scenario
    initial begin
        repeat (4) @(posedge CLK);
        RESETN <= 1'b1;
        t_erased();
        t_load_boot();
        t_irq();
        t_pw(1'b0, 16, 99);
        t_pw(1'b0, 16, 2);
        t_pw(1'b1, 3, 99);
        t_pw(1'b1, 3, 2);
        t_dbg_long();
        t_pw(1'b1, 60, 99);
        t_pw(1'b1, 60, 58);
        t_flags();
        tally_and_finish();
    end
endmodule : vts_vector_map_tb
